// [design/pstab_access.sv]
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Operation
// RULE1: Low table reads and writes reach the low 16-bit program word directly.
// RULE2: High table reads and writes are the only path to the upper 8 program bits as data.
// RULE3: Program addresses step by two per 24-bit word so they match data word addresses.
// RULE4: Program memory looks like two 16-bit spaces side by side with the same address range.
// RULE5: A word-mode low read returns program bits 15..0 on data bits 15..0.
// RULE6: A byte-mode low read puts the selected byte (1 upper, 0 lower) in the low data byte.
// RULE7: A word-mode high read returns program bits 23..16 in the low byte, upper byte zero.
// RULE8: A byte-mode high read returns bits 23..16 for select 0 and zero for the phantom byte.
// RULE9: Reads and writes both work as byte or word transfers.
// RULE10: Every table operation takes its page from the table page register.
// RULE11: Table page bit 7 clear selects user space and set selects configuration space.
// RULE12: In configuration space only reads at implemented locations run and writes are dropped.
// RULE13: The upper 32 Kbytes of data space map onto a 16K-word page set by the visibility page.
// RULE14: The program address counter is 23 bits wide.
// RULE15: A read of an unimplemented configuration location returns zero without side effects.
module pstab_access
  import pstab_pkg::*;
(
  // Clock and reset.
  input  wire logic          core_clk,
  input  wire logic          resetn,
  // Register port.
  input  wire logic [3:0]    reg_addr,
  input  wire logic [15:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [15:0]   reg_rdata,
  // Table requests from the core.
  input  pstab_req_type      tbl_req,
  output logic               tbl_done,
  output logic      [15:0]   tbl_rdata,
  output logic               tbl_refused,
  // Data-space window reads from the core.
  input  wire logic          vis_rd,
  input  wire logic [15:0]   vis_addr,
  output logic               vis_done,
  output logic      [15:0]   vis_rdata,
  // Program counter load and step from the core.
  input  wire logic          pc_load,
  input  wire logic [22:0]   pc_load_val,
  input  wire logic          pc_step,
  output logic      [22:0]   pc_value,
  // Program array.
  output pstab_mem_type      mem,
  input  wire logic [23:0]   mem_rdata
);

  typedef enum logic [1:0]
  {
    PSTAB_IDLE,
    PSTAB_TBL_WAIT,
    PSTAB_VIS_WAIT
  } pstab_state_type;

  typedef struct packed
  {
    pstab_state_type state;
    logic [7:0]      table_page;
    logic [7:0]      vis_page;
    logic [22:0]     pc;
    pstab_op_type    op;
    logic            byte_mode;
    logic            byte_sel;
    logic [15:0]     rdata;
    logic            done;
    logic            vdone;
    logic [15:0]     vrdata;
    logic            refused;
    logic [15:0]     reg_rdata;
    logic            wr_count_flag;
    pstab_mem_type   mem;
  } pstab_regs_type;

  pstab_regs_type state_r;
  pstab_regs_type state_nxt;

  ////////////////////////////////////////////////////////////////////////////////

  // Extract the data seen by a table read from one 24-bit program word.
  function automatic logic [15:0] read_shape(pstab_op_type op, logic byte_mode,
                                             logic byte_sel, logic [23:0] w);
    logic [15:0] r;
    r = 16'h0000;
    if (op == PSTAB_OP_READ_LOW)
    begin
      if (!byte_mode)
        r = w[15:0];                                   // RULE5
      else
        r = {8'h00, byte_sel ? w[15:8] : w[7:0]};      // RULE6
    end
    else
    begin
      if (!byte_mode)
        r = {8'h00, w[23:16]};                         // RULE7
      else
        r = {8'h00, byte_sel ? 8'h00 : w[23:16]};      // RULE8
    end
    return r;
  endfunction

  // Word address in the configuration page is implemented or not.
  function automatic logic cfg_impl(logic [15:0] addr);
    logic [15:0] word;
    word = {1'b0, addr[15:1]};
    return (word >= PSTAB_CFG_IMPL_LO) && (word <= PSTAB_CFG_IMPL_HI);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////

  always_comb
  begin
    logic        is_write;
    logic        is_cfg;
    logic [23:0] paddr;
    is_write  = 1'b0;
    is_cfg    = 1'b0;
    paddr     = 24'h000000;
    state_nxt = state_r;
    state_nxt.done      = 1'b0;
    state_nxt.vdone     = 1'b0;
    state_nxt.refused   = 1'b0;
    state_nxt.mem.rd    = 1'b0;
    state_nxt.mem.wr    = 1'b0;
    state_nxt.reg_rdata = 16'h0000;

    if (reg_wr)
    begin
      unique case (reg_addr)
        PSTAB_OFS_TABLE_PAGE: state_nxt.table_page = reg_wdata[7:0];
        PSTAB_OFS_VIS_PAGE:   state_nxt.vis_page   = reg_wdata[7:0];
        default:              state_nxt.table_page = state_r.table_page;
      endcase
    end
    if (reg_rd)
    begin
      unique case (reg_addr)
        PSTAB_OFS_TABLE_PAGE: state_nxt.reg_rdata = {8'h00, state_r.table_page};
        PSTAB_OFS_VIS_PAGE:   state_nxt.reg_rdata = {8'h00, state_r.vis_page};
        PSTAB_OFS_STATUS:     state_nxt.reg_rdata = {13'h0000, state_r.wr_count_flag,
                                                     state_r.state != PSTAB_IDLE,
                                                     state_r.table_page[PSTAB_CFG_SPACE_BIT]};
        default:              state_nxt.reg_rdata = 16'h0000;
      endcase
    end

    if (pc_load)
      state_nxt.pc = pc_load_val;                      // RULE14
    else if (pc_step)
      state_nxt.pc = state_r.pc + 23'h000002;          // RULE3

    unique case (state_r.state)
      PSTAB_IDLE:
      begin
        if (tbl_req.valid)
        begin
          is_write = (tbl_req.op == PSTAB_OP_WRITE_LOW) || (tbl_req.op == PSTAB_OP_WRITE_HIGH);
          is_cfg   = state_r.table_page[PSTAB_CFG_SPACE_BIT];         // RULE11
          // Page from the table page, word address straight from the data address.
          paddr    = {state_r.table_page, tbl_req.addr[15:1], 1'b0};  // RULE10 RULE3
          state_nxt.op        = tbl_req.op;
          state_nxt.byte_mode = tbl_req.byte_mode;                    // RULE9
          state_nxt.byte_sel  = tbl_req.addr[0];
          state_nxt.mem.addr  = paddr;
          state_nxt.mem.cfg   = is_cfg;
          if (is_cfg && (is_write || !cfg_impl(tbl_req.addr)))
          begin
            // Finish at once; nothing reaches the array.
            state_nxt.done    = 1'b1;                                 // RULE12 RULE15
            state_nxt.rdata   = 16'h0000;
            state_nxt.refused = is_write;
          end
          else if (is_write)
          begin
            state_nxt.mem.wr = 1'b1;
            state_nxt.done   = 1'b1;
            state_nxt.wr_count_flag = 1'b1;
            if (tbl_req.op == PSTAB_OP_WRITE_LOW)
            begin
              // Low space holds bits 15..0 only.                     // RULE1 RULE4
              state_nxt.mem.wdata   = {8'h00, tbl_req.wdata};
              state_nxt.mem.lane_en = tbl_req.byte_mode ?
                                      (tbl_req.addr[0] ? 3'h2 : 3'h1) : 3'h3;
            end
            else
            begin
              // Only the high path touches bits 23..16; phantom byte drops. // RULE2 RULE4
              state_nxt.mem.wdata   = {tbl_req.wdata[7:0], 16'h0000};
              state_nxt.mem.lane_en = (tbl_req.byte_mode && tbl_req.addr[0]) ? 3'h0 : 3'h4;
            end
          end
          else
          begin
            state_nxt.mem.rd = 1'b1;                                  // RULE1 RULE2
            state_nxt.state  = PSTAB_TBL_WAIT;
          end
        end
        else if (vis_rd && vis_addr[PSTAB_VIS_WIN_BIT])
        begin
          // 32 Kbyte window is 16K words: page supplies the upper address bits. // RULE13
          state_nxt.mem.addr  = {1'b0, state_r.vis_page, vis_addr[14:1], 1'b0};
          state_nxt.mem.cfg   = 1'b0;
          state_nxt.mem.rd    = 1'b1;
          state_nxt.byte_sel  = vis_addr[0];
          state_nxt.state     = PSTAB_VIS_WAIT;
        end
        else if (vis_rd)
        begin
          state_nxt.vdone  = 1'b1;
          state_nxt.vrdata = 16'h0000;
        end
      end
      PSTAB_TBL_WAIT:
      begin
        state_nxt.rdata = read_shape(state_r.op, state_r.byte_mode,
                                     state_r.byte_sel, mem_rdata);
        state_nxt.done  = 1'b1;
        state_nxt.state = PSTAB_IDLE;
      end
      PSTAB_VIS_WAIT:
      begin
        // The window only ever shows the low program word.
        state_nxt.vrdata = mem_rdata[15:0];
        state_nxt.vdone  = 1'b1;
        state_nxt.state  = PSTAB_IDLE;
      end
      default:
        state_nxt.state = PSTAB_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      state_r            <= '0;
      state_r.state      <= PSTAB_IDLE;
      state_r.table_page <= PSTAB_TABLE_PAGE_RST;
      state_r.vis_page   <= PSTAB_VIS_PAGE_RST;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign reg_rdata   = state_r.reg_rdata;
  assign tbl_done    = state_r.done;
  assign tbl_rdata   = state_r.rdata;
  assign tbl_refused = state_r.refused;
  assign vis_done    = state_r.vdone;
  assign vis_rdata   = state_r.vrdata;
  assign pc_value    = state_r.pc;
  assign mem         = state_r.mem;

endmodule

// [pkg/pstab_pkg.sv]
package pstab_pkg;

  // Register offsets on the plain register port.
  localparam logic [3:0]  PSTAB_OFS_TABLE_PAGE  = 4'h0;
  localparam logic [3:0]  PSTAB_OFS_VIS_PAGE    = 4'h1;
  localparam logic [3:0]  PSTAB_OFS_STATUS      = 4'h2;

  // Reset values.
  localparam logic [7:0]  PSTAB_TABLE_PAGE_RST  = 8'h00;
  localparam logic [7:0]  PSTAB_VIS_PAGE_RST    = 8'h00;

  // Field positions and widths.
  localparam int          PSTAB_CFG_SPACE_BIT   = 7;
  localparam int          PSTAB_PC_WIDTH        = 23;
  localparam int          PSTAB_PADDR_WIDTH     = 24;

  // Data-space window: upper 32 Kbytes, selected by data address bit 15.
  localparam int          PSTAB_VIS_WIN_BIT     = 15;

  // Configuration-space implemented area (word offsets within the page).
  localparam logic [15:0] PSTAB_CFG_IMPL_LO     = 16'h0000;
  localparam logic [15:0] PSTAB_CFG_IMPL_HI     = 16'h0003;

  typedef enum logic [1:0]
  {
    PSTAB_OP_READ_LOW,
    PSTAB_OP_READ_HIGH,
    PSTAB_OP_WRITE_LOW,
    PSTAB_OP_WRITE_HIGH
  } pstab_op_type;

  // One table request from the core.
  typedef struct packed
  {
    logic         valid;
    pstab_op_type op;
    logic         byte_mode;
    logic [15:0]  addr;
    logic [15:0]  wdata;
  } pstab_req_type;

  // One access toward the program array.
  typedef struct packed
  {
    logic        rd;
    logic        wr;
    logic        cfg;
    logic [23:0] addr;
    logic [23:0] wdata;
    logic [2:0]  lane_en;
  } pstab_mem_type;

endpackage

// [dv/pstab_access_props.sv]
`timescale 1ns/1ns
module pstab_access_props
  import pstab_pkg::*;
(
  // Clock and reset.
  input wire logic        core_clk,
  input wire logic        resetn,
  // Core side.
  input pstab_req_type    tbl_req,
  input wire logic        tbl_done,
  input wire logic [15:0] tbl_rdata,
  input wire logic        tbl_refused,
  input wire logic        vis_rd,
  input wire logic [15:0] vis_addr,
  input wire logic        vis_done,
  input wire logic [15:0] vis_rdata,
  input wire logic        pc_load,
  input wire logic [22:0] pc_load_val,
  input wire logic        pc_step,
  input wire logic [22:0] pc_value,
  // Array side.
  input pstab_mem_type    mem
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  a_rd_answered: assert property (mem.rd |-> !mem.addr[0] ##1 (tbl_done || vis_done))
    else $error("array read not answered");
  a_wr_user_only: assert property (mem.wr |-> tbl_done && !tbl_refused && !mem.cfg)
    else $error("write reached configuration space");
  a_refuse_quiet: assert property (tbl_refused |-> tbl_done && !mem.wr && !mem.rd)
    else $error("refused write touched the array");
  a_high_zero: assert property (tbl_req.valid && tbl_req.op == PSTAB_OP_READ_HIGH ##2 tbl_done
    |-> tbl_rdata[15:8] == 8'h00)
    else $error("phantom byte not zero");
  a_pc_step: assert property (pc_step && !pc_load
    |=> pc_value == $past(pc_value) + 23'h000002)
    else $error("counter did not step by two");
  a_pc_load: assert property (pc_load |=> pc_value == $past(pc_load_val))
    else $error("counter load lost");
  a_vis_map: assert property (vis_rd && vis_addr[15] && !tbl_req.valid |=> mem.rd && !mem.cfg
    && !mem.addr[23] && mem.addr[14:1] == $past(vis_addr[14:1]))
    else $error("window read mapped wrongly");
  a_vis_low: assert property (vis_rd && !vis_addr[15] && !tbl_req.valid
    |=> vis_done && vis_rdata == 16'h0000 && !mem.rd)
    else $error("lower data read reached the array");
endmodule

// [dv/pstab_prog_model.sv]
`timescale 1ns/1ns
module pstab_prog_model
  import pstab_pkg::*;
(
  // Array port.
  input wire logic        core_clk,
  input pstab_mem_type    mem,
  output logic     [23:0] mem_rdata
);
  logic [23:0] store [logic [24:0]];
  logic [23:0] held_r;
  logic        held_v_r = 1'b0;
  logic [23:0] wr_word;

  function automatic logic [23:0] word_at(input logic cfg, input logic [23:0] a);
    if (store.exists({cfg, a}))
      return store[{cfg, a}];
    return {a[7:0] ^ 8'h3C, a[15:8], a[23:16] ^ {cfg, 7'h25}};
  endfunction

  // Data stand in the read cycle and the next one only; after that the lines toggle
  // every cycle so a late sample cannot pass by luck.
  assign mem_rdata = mem.rd ? word_at(mem.cfg, mem.addr) : (held_v_r ? held_r : ~held_r);

  always @(posedge core_clk)
  begin
    held_v_r <= mem.rd;
    held_r <= mem.rd ? word_at(mem.cfg, mem.addr) : (held_v_r ? held_r : ~held_r);
    if (mem.wr)
    begin
      wr_word = word_at(mem.cfg, mem.addr);
      for (int k = 0; k < 3; k++)
        if (mem.lane_en[k])
          wr_word[8*k +: 8] = mem.wdata[8*k +: 8];
      store[{mem.cfg, mem.addr}] = wr_word;
    end
  end
endmodule

// [dv/pstab_access_bench.sv]
`timescale 1ns/1ns
module pstab_access_bench
  import pstab_pkg::*;
  ;
  logic          core_clk = 1'b0;
  logic          resetn = 1'b0;
  logic [3:0]    reg_addr = 4'h0;
  logic [15:0]   reg_wdata = 16'h0000;
  logic          reg_wr = 1'b0;
  logic          reg_rd = 1'b0;
  logic [15:0]   reg_rdata, tbl_rdata, vis_rdata;
  pstab_req_type tbl_req = '0;
  logic          tbl_done, tbl_refused, vis_done;
  logic          vis_rd = 1'b0;
  logic [15:0]   vis_addr = 16'h0000;
  logic          pc_load = 1'b0;
  logic          pc_step = 1'b0;
  logic [22:0]   pc_load_val = 23'h000000;
  logic [22:0]   pc_value;
  pstab_mem_type mem;
  logic [23:0]   mem_rdata;
  logic [17:0]   exp_q [$];
  logic [17:0]   note;
  logic          rd_seen = 1'b0;
  int            error_cnt = 0;
  int            checks_done = 0;
  int            seed = 71852;

  always #25 core_clk = ~core_clk;
  pstab_access u_pstab_access
  (
    .core_clk    (core_clk),
    .resetn      (resetn),
    .reg_addr    (reg_addr),
    .reg_wdata   (reg_wdata),
    .reg_wr      (reg_wr),
    .reg_rd      (reg_rd),
    .reg_rdata   (reg_rdata),
    .tbl_req     (tbl_req),
    .tbl_done    (tbl_done),
    .tbl_rdata   (tbl_rdata),
    .tbl_refused (tbl_refused),
    .vis_rd      (vis_rd),
    .vis_addr    (vis_addr),
    .vis_done    (vis_done),
    .vis_rdata   (vis_rdata),
    .pc_load     (pc_load),
    .pc_load_val (pc_load_val),
    .pc_step     (pc_step),
    .pc_value    (pc_value),
    .mem         (mem),
    .mem_rdata   (mem_rdata)
  );
  pstab_prog_model u_pstab_prog_model (.core_clk(core_clk), .mem(mem), .mem_rdata(mem_rdata));

////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
    checks_done++;
    if (seen !== want)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, input logic [15:0] want);
    exp_q.push_back({2'b10, want});
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
  endtask

  // The done pulse may already be visible at the edge that drops the request.
  task automatic wait_done(input logic vis);
    int n;
    n = 0;
    while ((vis ? vis_done : tbl_done) !== 1'b1 && n < 20)
    begin
      @(posedge core_clk);
      n++;
    end
    if (n == 20)
    begin
      error_cnt++;
      $display("ERROR completion expected 1 seen 0");
    end
  endtask

  task automatic tbl_op(input pstab_op_type op, input logic bm, input logic [15:0] a,
    input logic [15:0] wd, input logic [17:0] n);
    exp_q.push_back(n);
    @(posedge core_clk);
    tbl_req <= '{1'b1, op, bm, a, wd};
    @(posedge core_clk);
    tbl_req.valid <= 1'b0;
    wait_done(1'b0);
  endtask

  task automatic vis_op(input logic [15:0] a, input logic [15:0] want);
    exp_q.push_back({2'b10, want});
    @(posedge core_clk);
    vis_rd <= 1'b1;
    vis_addr <= a;
    @(posedge core_clk);
    vis_rd <= 1'b0;
    wait_done(1'b1);
  endtask

////////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk)
  begin
    if (rd_seen || tbl_done === 1'b1 || vis_done === 1'b1)
    begin
      note = exp_q.size() > 0 ? exp_q.pop_front() : 18'h3FFFF;
      if (note[17])
        check("read data", tbl_done === 1'b1 ? tbl_rdata : vis_done === 1'b1 ? vis_rdata
          : reg_rdata, note[15:0]);
      if (tbl_done === 1'b1)
        check("refused", {15'h0000, tbl_refused}, {15'h0000, note[16]});
    end
    rd_seen = reg_rd;
  end

  initial
  begin
    #(3000 * 50);
    error_cnt++;
    complete_run();
  end

  initial
  begin
    logic [15:0] a;
    logic [23:0] w;
    logic [7:0]  pg;
    logic [7:0]  vp;
    logic [15:0] ed;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    a = 16'($random(seed));
    pg = {1'b0, a[6:0]};
    vp = a[15:8];
    reg_write(PSTAB_OFS_TABLE_PAGE, {8'h00, pg});
    reg_write(PSTAB_OFS_VIS_PAGE, {8'h00, vp});
    reg_read(PSTAB_OFS_TABLE_PAGE, {8'h00, pg});
    reg_read(PSTAB_OFS_VIS_PAGE, {8'h00, vp});
    reg_read(4'hF, 16'h0000);
    for (int i = 0; i < 16; i++)
    begin
      a = 16'($random(seed));
      w = u_pstab_prog_model.word_at(1'b0, {pg, a[15:1], 1'b0});
      if (i[1])
        ed = {8'h00, i[0] ? (a[0] ? 8'h00 : w[23:16]) : (a[0] ? w[15:8] : w[7:0])};
      else
        ed = i[0] ? {8'h00, w[23:16]} : w[15:0];
      tbl_op(i[0] ? PSTAB_OP_READ_HIGH : PSTAB_OP_READ_LOW, i[1], a, 16'h0000, {2'b10, ed});
    end
    tbl_op(PSTAB_OP_WRITE_LOW, 1'b0, 16'h0040, 16'hA55A, 18'h00000);
    tbl_op(PSTAB_OP_WRITE_HIGH, 1'b0, 16'h0040, 16'h00C3, 18'h00000);
    tbl_op(PSTAB_OP_WRITE_HIGH, 1'b1, 16'h0041, 16'hFFFF, 18'h00000);
    tbl_op(PSTAB_OP_READ_LOW, 1'b0, 16'h0040, 16'h0000, {2'b10, 16'hA55A});
    tbl_op(PSTAB_OP_READ_HIGH, 1'b0, 16'h0040, 16'h0000, {2'b10, 16'h00C3});
    reg_write(PSTAB_OFS_TABLE_PAGE, 16'h0080);
    // Status: a write has happened, idle, configuration space selected.
    reg_read(PSTAB_OFS_STATUS, 16'h0005);
    w = u_pstab_prog_model.word_at(1'b1, 24'h800000);
    tbl_op(PSTAB_OP_WRITE_LOW, 1'b0, 16'h0000, 16'h1234, {2'b01, 16'h0000});
    tbl_op(PSTAB_OP_READ_LOW, 1'b0, 16'h0000, 16'h0000, {2'b10, w[15:0]});
    tbl_op(PSTAB_OP_READ_LOW, 1'b0, 16'h0100, 16'h0000, {2'b10, 16'h0000});
    a = 16'($random(seed)) | 16'h8000;
    w = u_pstab_prog_model.word_at(1'b0, {1'b0, vp, a[14:1], 1'b0});
    vis_op(a, w[15:0]);
    vis_op(a & 16'h7FFF, 16'h0000);
    @(posedge core_clk);
    pc_load <= 1'b1;
    pc_load_val <= 23'h7FFFFE;
    @(posedge core_clk);
    pc_load <= 1'b0;
    pc_step <= 1'b1;
    repeat (2) @(posedge core_clk);
    pc_step <= 1'b0;
    repeat (3) @(posedge core_clk);
    // Two steps from the top of the range wrap the 23-bit counter to 2.
    check("pc low", pc_value[15:0], 16'h0002);
    check("pc high", {9'h000, pc_value[22:16]}, 16'h0000);
    complete_run();
  end
endmodule

bind pstab_access pstab_access_props u_pstab_access_props
(
  .core_clk    (core_clk),
  .resetn      (resetn),
  .tbl_req     (tbl_req),
  .tbl_done    (tbl_done),
  .tbl_rdata   (tbl_rdata),
  .tbl_refused (tbl_refused),
  .vis_rd      (vis_rd),
  .vis_addr    (vis_addr),
  .vis_done    (vis_done),
  .vis_rdata   (vis_rdata),
  .pc_load     (pc_load),
  .pc_load_val (pc_load_val),
  .pc_step     (pc_step),
  .pc_value    (pc_value),
  .mem         (mem)
);
